// >>> hde_top.sv
/*
  Headset detection and event interrupt logic: jack and button debounce,
  live and sticky clear-on-read flags, headset type report and two
  interrupt lines with single pulse or pulse train output.
  Assumes all inputs synchronous to clock and a decoded 8-bit register
  port from the control interface: one-cycle reg_wr and reg_rd strobes.
*/
// Summary of operation
// - detection runs only while bit 1 of the detection control register is 1.
// - headset insertion is debounced over 32 to 512 ms chosen by bits 4..2.
// - button press is debounced over 32 ms whenever detection runs, as bits 1..0 then read 2 or 3.
// - live status bits 5..4 show the current button and headset levels.
// - sticky flag bit 5 is set by every debounced button press.
// - sticky flag bit 4 is set by every debounced insertion or removal.
// - sticky flags hold until the host reads their register, which clears them.
// - the headset type is reported in bits 6..5 of detection control.
// - two interrupt lines, each set up by its own control register.
// - each line fires on any selected mix of seven events, shared freely.
// - each line can be routed to the general output or serial data pin.
// - bit 0 of each interrupt control picks single pulse or pulse train.
// - a pulse train runs until the host reads a flag register.
// - compressor over-threshold sets sticky bits 3..2 and live bits 3..2.
`timescale 1ns/100ps
`default_nettype none
module hde_top #(
  parameter int unsigned HS_BASE_CYC  = hde_pkg::HS_DEB_MIN_CYC,
  parameter int unsigned BTN_BASE_CYC = hde_pkg::BTN_DEB_MIN_CYC
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       jack_sense,
  input  wire logic       button_sense,
  input  wire logic [1:0] headset_type_in,
  input  wire logic [1:0] drc_over_thresh,
  input  wire logic       agc_noise,
  input  wire logic       overcurrent,
  input  wire logic       proc_overflow,
  input  wire logic       dc_meas_ready,
  input  wire logic       first_route_dout,
  input  wire logic       second_route_dout,
  output logic            first_interrupt_line,
  output logic            second_interrupt_line,
  output logic            general_output_pin_one,
  output logic            serial_data_out_int
);
  logic [7:0]             det_ctrl_reg;
  logic [1:0]             hs_type_reg;
  hde_pkg::hde_int_ctrl_t int_ctrl_reg [2];
  logic [5:2]             sticky_reg;
  logic [1:0]             drc_prev_reg;
  logic [3:0]             misc_prev_reg;
  logic                   det_en;
  logic [2:0]             hs_code;
  logic [1:0]             btn_code;
  logic [hde_pkg::DEB_W-1:0] hs_hold;
  logic [hde_pkg::DEB_W-1:0] btn_hold;
  logic                   hs_level;
  logic                   hs_changed;
  logic                   btn_level;
  logic                   btn_changed;
  logic                   btn_press;
  logic                   drc_rise;
  logic [1:0]             drc_set;
  logic [3:0]             misc_rise;
  hde_pkg::hde_evt_t      evt;
  logic                   rd_sticky;
  logic                   rd_any_flags;
  logic [3:0]             sticky_set;
  logic [7:0]             rd_mux;
  logic [1:0]             line_on;
  logic [1:0]             line_trig;

  // detection control fields; bit 1 is both enable and debounce msb
  assign det_en   = det_ctrl_reg[hde_pkg::DET_EN_BIT];
  assign hs_code  = det_ctrl_reg[hde_pkg::HS_DEB_LO +: 3];
  assign btn_code = det_ctrl_reg[hde_pkg::BTN_DEB_LO +: 2];

  // debounce windows double per code and saturate at the longest
  always_comb begin
    if (int'(hs_code) >= hde_pkg::HS_DEB_MAX_SHIFT) begin
      hs_hold = hde_pkg::DEB_W'(HS_BASE_CYC << hde_pkg::HS_DEB_MAX_SHIFT);
    end else begin
      hs_hold = hde_pkg::DEB_W'(HS_BASE_CYC << hs_code);
    end
    if (int'(btn_code) >= hde_pkg::BTN_DEB_MAX_SHIFT) begin
      btn_hold = hde_pkg::DEB_W'(BTN_BASE_CYC << hde_pkg::BTN_DEB_MAX_SHIFT);
    end else begin
      btn_hold = hde_pkg::DEB_W'(BTN_BASE_CYC << btn_code);
    end
  end

  hde_debounce u_hs_deb (
    .clock       (clock),
    .reset_n     (reset_n),
    .enable      (det_en),
    .raw         (jack_sense),
    .hold_cycles (hs_hold),
    .level_reg   (hs_level),
    .changed_reg (hs_changed)
  );

  hde_debounce u_btn_deb (
    .clock       (clock),
    .reset_n     (reset_n),
    .enable      (det_en),
    .raw         (button_sense),
    .hold_cycles (btn_hold),
    .level_reg   (btn_level),
    .changed_reg (btn_changed)
  );

  // only the press edge counts, a release is no event
  assign btn_press = btn_changed & btn_level;

  // edge detect of level-type event inputs
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      drc_prev_reg  <= 2'h0;
      misc_prev_reg <= 4'h0;
    end else begin
      drc_prev_reg  <= drc_over_thresh;
      misc_prev_reg <= {agc_noise, overcurrent, proc_overflow,
                        dc_meas_ready};
    end
  end

  assign drc_set   = drc_over_thresh & ~drc_prev_reg;
  assign drc_rise  = |drc_set;
  assign misc_rise = {agc_noise, overcurrent, proc_overflow, dc_meas_ready}
                     & ~misc_prev_reg;

  // event vector shared by both interrupt lines
  assign evt = '{headset:     hs_changed,
                 button:      btn_press,
                 dynamic_range_compressor:         drc_rise,
                 agc_noise:   misc_rise[3],
                 overcurrent: misc_rise[2],
                 overflow:    misc_rise[1],
                 dc_ready:    misc_rise[0]};

  assign rd_sticky    = reg_rd && (reg_addr == hde_pkg::STICKY_FLAGS_ADDR);
  assign rd_any_flags = rd_sticky
                        || (reg_rd && reg_addr == hde_pkg::FLAGS_B_ADDR)
                        || (reg_rd && reg_addr == hde_pkg::FLAGS_C_ADDR);
  assign sticky_set   = {btn_press, hs_changed, drc_set};

  // sticky flags: cleared by a read, but a same-cycle event wins
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sticky_reg <= hde_pkg::FLAGS_RST[5:2];
    end else begin
      sticky_reg <= (rd_sticky ? 4'h0 : sticky_reg) | sticky_set;
    end
  end

  // control registers; type field is read-only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      det_ctrl_reg    <= hde_pkg::DET_CTRL_RST;
      int_ctrl_reg[0] <= hde_pkg::INT_CTRL_RST;
      int_ctrl_reg[1] <= hde_pkg::INT_CTRL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        hde_pkg::DET_CTRL_ADDR:
          det_ctrl_reg <= reg_wdata & hde_pkg::DET_CTRL_RW_MASK;
        hde_pkg::FIRST_INTERRUPT_LINE_CTRL_ADDR: int_ctrl_reg[0] <= reg_wdata;
        hde_pkg::SECOND_INTERRUPT_LINE_CTRL_ADDR: int_ctrl_reg[1] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // headset type caught on insertion, dropped on removal
  always_ff @(posedge clock) begin
    if (!reset_n || !det_en) begin
      hs_type_reg <= 2'h0;
    end else if (hs_changed) begin
      hs_type_reg <= hs_level ? headset_type_in : 2'h0;
    end
  end

  // read data mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      hde_pkg::STICKY_FLAGS_ADDR: rd_mux = {2'h0, sticky_reg, 2'h0};
      hde_pkg::LIVE_STATUS_ADDR:
        rd_mux = {2'h0, btn_level, hs_level, drc_over_thresh, 2'h0};
      hde_pkg::FIRST_INTERRUPT_LINE_CTRL_ADDR: rd_mux = int_ctrl_reg[0];
      hde_pkg::SECOND_INTERRUPT_LINE_CTRL_ADDR: rd_mux = int_ctrl_reg[1];
      hde_pkg::DET_CTRL_ADDR:
        rd_mux = {1'b0, hs_type_reg, det_ctrl_reg[4:0]};
      default: rd_mux = 8'h00;
    endcase
  end

  // read answer one cycle after the strobe, flags as before the clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // pulse generator per interrupt line
  for (genvar i = 0; i < 2; i++) begin : g_line
    logic [15:0] hi_cnt_reg;
    logic [15:0] per_cnt_reg;
    logic        train_reg;

    assign line_trig[i] = |(evt & int_ctrl_reg[i][7:1]);
    assign line_on[i]   = (hi_cnt_reg != 16'h0);

    // train stays armed until a flag read; a new event outranks the read
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        train_reg <= 1'b0;
      end else if (line_trig[i] && int_ctrl_reg[i].train) begin
        train_reg <= 1'b1;
      end else if (rd_any_flags || !int_ctrl_reg[i].train) begin
        train_reg <= 1'b0;
      end
    end

    // width and repeat counters; a retrigger restarts the pulse
    always_ff @(posedge clock) begin
      if (!reset_n) begin
        hi_cnt_reg  <= 16'h0;
        per_cnt_reg <= 16'h0;
      end else if (line_trig[i]) begin
        hi_cnt_reg  <= hde_pkg::PULSE_CYC;
        per_cnt_reg <= hde_pkg::PERIOD_CYC;
      end else begin
        if (train_reg && per_cnt_reg == 16'h1) begin
          hi_cnt_reg  <= hde_pkg::PULSE_CYC;
          per_cnt_reg <= hde_pkg::PERIOD_CYC;
        end else begin
          if (line_on[i]) begin
            hi_cnt_reg <= hi_cnt_reg - 16'h1;
          end
          if (per_cnt_reg != 16'h0) begin
            per_cnt_reg <= per_cnt_reg - 16'h1;
          end
        end
      end
    end
  end

  // registered line and pin outputs; both lines may share one pin
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      first_interrupt_line   <= 1'b0;
      second_interrupt_line  <= 1'b0;
      general_output_pin_one <= 1'b0;
      serial_data_out_int    <= 1'b0;
    end else begin
      first_interrupt_line   <= line_on[0];
      second_interrupt_line  <= line_on[1];
      general_output_pin_one <= (line_on[0] & ~first_route_dout)
                              | (line_on[1] & ~second_route_dout);
      serial_data_out_int    <= (line_on[0] & first_route_dout)
                              | (line_on[1] & second_route_dout);
    end
  end
endmodule
`default_nettype wire

// >>> hde_pkg.sv
/*
  Package for the headset detect and event interrupt block: register
  offsets, field positions, reset values, timing constants and carriers.
  Assumes a 200 MHz core clock and the 8-bit register port of the top.
*/
package hde_pkg;

  // register offsets
  localparam logic [7:0] STICKY_FLAGS_ADDR = 8'h2C;
  localparam logic [7:0] FLAGS_B_ADDR      = 8'h2D;
  localparam logic [7:0] LIVE_STATUS_ADDR  = 8'h2E;
  localparam logic [7:0] FIRST_INTERRUPT_LINE_CTRL_ADDR    = 8'h30;
  localparam logic [7:0] SECOND_INTERRUPT_LINE_CTRL_ADDR    = 8'h31;
  localparam logic [7:0] FLAGS_C_ADDR      = 8'h32;
  localparam logic [7:0] DET_CTRL_ADDR     = 8'h43;

  // field positions
  localparam int BTN_FLAG_BIT   = 5;
  localparam int HS_FLAG_BIT    = 4;
  localparam int DRC_FLAG_LO    = 2;
  localparam int DET_EN_BIT     = 1;
  localparam int HS_DEB_LO      = 2;
  localparam int BTN_DEB_LO     = 0;
  localparam int HS_TYPE_LO     = 5;
  localparam logic [7:0] DET_CTRL_RW_MASK = 8'h1F;

  // reset values
  localparam logic [7:0] DET_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST    = 8'h00;

  // timing
  localparam int unsigned CLK_KHZ       = 200000;
  localparam int unsigned HS_DEB_MIN_MS  = 32;
  localparam int unsigned BTN_DEB_MIN_MS = 8;
  localparam int unsigned HS_DEB_MIN_CYC  = HS_DEB_MIN_MS * CLK_KHZ;
  localparam int unsigned BTN_DEB_MIN_CYC = BTN_DEB_MIN_MS * CLK_KHZ;
  localparam int          HS_DEB_MAX_SHIFT = 4;  // 32 ms << 4 = 512 ms
  localparam int          BTN_DEB_MAX_SHIFT = 2; // 8 ms << 2 = 32 ms
  localparam int unsigned PULSE_NS  = 1000;
  localparam int unsigned PERIOD_NS = 4000;
  localparam logic [15:0] PULSE_CYC  = 16'(PULSE_NS * CLK_KHZ / 1000000);
  localparam logic [15:0] PERIOD_CYC = 16'(PERIOD_NS * CLK_KHZ / 1000000);
  localparam int DEB_W = 27;

  // interrupt control register layout, msb first
  typedef struct packed {
    logic headset;
    logic button;
    logic dynamic_range_compressor;
    logic agc_noise;
    logic overcurrent;
    logic overflow;
    logic dc_ready;
    logic train;
  } hde_int_ctrl_t;

  // event pulses in the same order as the select bits
  typedef struct packed {
    logic headset;
    logic button;
    logic dynamic_range_compressor;
    logic agc_noise;
    logic overcurrent;
    logic overflow;
    logic dc_ready;
  } hde_evt_t;

endpackage

// >>> hde_debounce.sv
/*
  Debounce filter for one sense level. The output follows the raw input
  only after it has differed for hold_cycles cycles in a row.
  Assumes raw is synchronous to clock.
*/
`timescale 1ns/100ps
`default_nettype none
module hde_debounce (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    enable,
  input  wire logic                    raw,
  input  wire logic [hde_pkg::DEB_W-1:0] hold_cycles,
  output logic                         level_reg,
  output logic                         changed_reg
);
  logic [hde_pkg::DEB_W-1:0] cnt_reg;

  // disabled filter reads as no plug and no press
  always_ff @(posedge clock) begin
    if (!reset_n || !enable) begin
      cnt_reg     <= '0;
      level_reg   <= 1'b0;
      changed_reg <= 1'b0;
    end else begin
      changed_reg <= 1'b0;
      if (raw == level_reg) begin
        cnt_reg <= '0; // any glitch restarts the wait
      end else if (cnt_reg + 1'b1 >= hold_cycles) begin
        cnt_reg     <= '0;
        level_reg   <= raw;
        changed_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hde_props.sv
/*
  Port checker for the headset detect and interrupt block.
  Assumes it is bound into every hde_top instance.
*/
`timescale 1ns/100ps
`default_nettype none
module hde_props #(
  parameter int unsigned HS_BASE_CYC  = 1,
  parameter int unsigned BTN_BASE_CYC = 1
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       first_route_dout,
  input wire logic       first_interrupt_line,
  input wire logic       second_interrupt_line,
  input wire logic       general_output_pin_one
);
  logic [15:0] hi_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // high run of line one; a retrigger would stretch it
  always_ff @(posedge clock) begin
    if (!reset_n || !first_interrupt_line) hi_reg <= 16'h0000;
    else hi_reg <= hi_reg + 16'h0001;
  end

  rd_valid_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (reg_rd && !(reg_addr inside
    {8'h2C, 8'h2D, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h43}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property ((reg_wr && reg_addr == 8'h30)
    ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h30)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("interrupt control readback wrong");
  det_readback_a: assert property ((reg_wr && reg_addr == 8'h43)
    ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'h43)
    |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3) && !reg_rdata[7])
    else $error("detect control readback wrong");
  pulse_width_a: assert property ($fell(first_interrupt_line)
    |-> hi_reg == hde_pkg::PULSE_CYC)
    else $error("line one pulse width wrong");
  gpio_route_a: assert property (first_interrupt_line
    && !first_route_dout && !$past(first_route_dout)
    |-> general_output_pin_one)
    else $error("line one missing on general pin");
  pin_source_a: assert property (general_output_pin_one
    |-> first_interrupt_line || second_interrupt_line)
    else $error("general pin high with no line");

  c_line1: cover property ($rose(first_interrupt_line));
  c_line2: cover property ($rose(second_interrupt_line));
  c_pin: cover property ($rose(general_output_pin_one));
endmodule

bind hde_top hde_props #(
  .HS_BASE_CYC (HS_BASE_CYC),
  .BTN_BASE_CYC(BTN_BASE_CYC)
) props (.clock, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .reg_rvalid, .first_route_dout, .first_interrupt_line,
  .second_interrupt_line, .general_output_pin_one);
`default_nettype wire

// >>> hde_host.sv
/*
  Host model: register strobes and interrupt pin edge counts.
  Assumes strobes are taken on the rising edge after they are set.
*/
`timescale 1ns/100ps
`default_nettype none
module hde_host (
  input  wire logic       clock,
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       general_output_pin_one,
  input  wire logic       serial_data_out_int
);
  int gpio_n = 0;
  int dout_n = 0;

  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // pulses seen on each pin
  always @(posedge general_output_pin_one) gpio_n++;
  always @(posedge serial_data_out_int) dout_n++;

  // released lines flip so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // reading a flag register also ends a pulse train
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> test_headset_detect_event_interrupts.sv
/*
  Testbench for hde_top with short debounce counts.
  Assumes hde_host drives the register port.
*/
`timescale 1ns/100ps
`default_nettype none
module test_headset_detect_event_interrupts;
  logic clock, reset_n, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic jack_sense, button_sense, r1, r2, l1, l2, gp, dout;
  logic [1:0] headset_type_in;
  logic [4:0] ev;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int g0, d0, l10, l20;
  int l1_n = 0;
  int l2_n = 0;

  // rising edges of each interrupt line, whatever pin it is routed to
  always @(posedge l1) l1_n++;
  always @(posedge l2) l2_n++;

  hde_top #(.HS_BASE_CYC(20), .BTN_BASE_CYC(5)) dut (
    .clock, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .jack_sense, .button_sense, .headset_type_in,
    .drc_over_thresh({1'b0, ev[4]}), .agc_noise(ev[3]),
    .overcurrent(ev[2]), .proc_overflow(ev[1]), .dc_meas_ready(ev[0]),
    .first_route_dout(r1), .second_route_dout(r2),
    .first_interrupt_line(l1), .second_interrupt_line(l2),
    .general_output_pin_one(gp), .serial_data_out_int(dout));
  hde_host hs (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .general_output_pin_one(gp), .serial_data_out_int(dout));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang counts against the run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_n(input string n, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      error_cnt++;
      $display("BAD %s exp %0d got %0d", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    hs.rd(a, d);
    chk(n, e, d);
  endtask

  // reset values, readback, read-only and unmapped, detection off
  task automatic t_regs_off;
    rchk("det_ctrl", 8'h43, 8'h00);
    rchk("second_interrupt_line_ctrl", 8'h31, 8'h00);
    rchk("unmapped", 8'h55, 8'h00);
    hs.wr(8'h30, 8'hA4);
    rchk("first_interrupt_line_ctrl", 8'h30, 8'hA4);
    jack_sense = 1'b1;
    hs.wr(8'h2E, 8'hFF);
    repeat (40) @(negedge clock);
    rchk("live_off", 8'h2E, 8'h00);
    rchk("sticky_off", 8'h2C, 8'h00);
    jack_sense = 1'b0;
    hs.wr(8'h43, 8'hFF);
    rchk("det_mask", 8'h43, 8'h1F);
  endtask

  // insertion: flags, type, single pulse on one line, train on the other
  task automatic t_jack;
    hs.wr(8'h43, 8'h02);
    hs.wr(8'h30, 8'h80);
    hs.wr(8'h31, 8'hC1);
    g0 = hs.gpio_n;
    d0 = hs.dout_n;
    l10 = l1_n;
    l20 = l2_n;
    headset_type_in = 2'b10;
    jack_sense = 1'b1;
    repeat (40) @(negedge clock);
    rchk("live_hs", 8'h2E, 8'h10);
    rchk("hs_type", 8'h43, 8'h42);
    repeat (960) @(negedge clock);
    chk_n("single", g0 + 1, hs.gpio_n);
    chk_n("train", d0 + 2, hs.dout_n);
    chk_n("line1_edges", l10 + 1, l1_n);
    chk_n("line2_edges", l20 + 2, l2_n);
    rchk("sticky_hs", 8'h2C, 8'h10);
    rchk("sticky_clr", 8'h2C, 8'h00);
    repeat (1000) @(negedge clock);
    chk_n("train_stop", d0 + 2, hs.dout_n);
  endtask

  // button press sets its own flag and level; line two moved to gpio
  task automatic t_button;
    g0 = hs.gpio_n;
    d0 = hs.dout_n;
    r2 = 1'b0;
    button_sense = 1'b1;
    repeat (40) @(negedge clock);
    rchk("sticky_btn", 8'h2C, 8'h20);
    rchk("live_btn", 8'h2E, 8'h30);
    button_sense = 1'b0;
    repeat (300) @(negedge clock);
    chk_n("gpio_line2", g0 + 1, hs.gpio_n);
    chk_n("dout_line2", d0, hs.dout_n);
    r2 = 1'b1;
  endtask

  // removal with a doubled window: level holds, then drops, flag set and type cleared
  task automatic t_removal;
    hs.wr(8'h43, 8'h06);
    jack_sense = 1'b0;
    repeat (30) @(negedge clock);
    rchk("live_wait", 8'h2E, 8'h10);
    repeat (30) @(negedge clock);
    rchk("live_out", 8'h2E, 8'h00);
    rchk("sticky_out", 8'h2C, 8'h10);
    rchk("type_out", 8'h43, 8'h06);
  endtask

  // compressor edge in the cycle of a clearing read must not be lost
  task automatic t_read_race;
    fork
      hs.rd(8'h2C, d);
      begin
        @(negedge clock);
        ev[4] = 1'b1;
      end
    join
    chk("race_read", 8'h00, d);
    rchk("sticky_keep", 8'h2C, 8'h04);
    rchk("live_drc", 8'h2E, 8'h04);
    ev[4] = 1'b0;
  endtask

  // each other event fires line one, routed to alternating pins
  task automatic t_events;
    hs.wr(8'h30, 8'h3E);
    g0 = hs.gpio_n;
    d0 = hs.dout_n;
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      r1 = i[0];
      ev[i] = 1'b1;
      repeat (300) @(negedge clock);
      ev[i] = 1'b0;
    end
    chk_n("gpio_events", g0 + 3, hs.gpio_n);
    chk_n("dout_events", d0 + 2, hs.dout_n);
    rchk("sticky_drc", 8'h2C, 8'h04);
  endtask

  initial begin
    reset_n = 1'b0;
    jack_sense = 1'b0;
    button_sense = 1'b0;
    headset_type_in = 2'b00;
    ev = 5'h00;
    r1 = 1'b0;
    r2 = 1'b1;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    t_regs_off();
    t_jack();
    t_button();
    t_events();
    t_removal();
    t_read_race();
    final_report();
  end
endmodule
`default_nettype wire
